// >>> src/ceau_pkg.sv
// Constants and types for the effective address unit
// Notes on behaviour
// (RL1) Reset loads PC from vector, sets mask
// (RL2) Reset leaves other flags, registers untouched
// (RL3) Software sets stack pointer first after reset
// (RL4) Bit ops act on bit 0..7
// (RL5) Word operands only for listed instructions
// (RL6) Decimal adjust keeps nibbles valid digits
// (RL7) Word accesses and fetches force bit0 zero; jump targets by AM_IND or AM_ABS16 keep bit0 unless word_in is set
// (RL8) Flags pushed as doubled byte word
// (RL9) Stack accessed by words only; byte post-increment and pre-decrement on register 7 still step by one
// (RL10) Displacement mode add_small_const 16-bit displacement
// (RL11) Post-increment add_small_const one or two after
// (RL12) Pre-decrement subtracts first, keeps result
// (RL13) Software keeps word move addresses even
// (RL14) Short absolute fills upper byte ones
// (RL15) Long absolute only move and jumps
// (RL16) Immediates from byte two or three-four
// (RL17) Implied constants one/two, 3-bit bit numbers; imm_out gives two only, as the group is legal with word_in only
// (RL18) Relative branch sign-extends displacement
// (RL19) Memory indirect reads page-zero word
// (RL20) ALU ops register direct, some immediate
// (RL21) Transfers use all but relative, indirect; word moves also refuse AM_ABS8 and AM_IMM8, byte moves AM_IMM16
// (RL22) Bit ops: direct, indirect, short absolute
// (RL23) Sixteen byte halves, register seven stack
// (RL24) Address sums wrap modulo 65536
package ceau_pkg;
  // Address width and register count
  localparam int ADDR_W = 16;
  localparam int NREG   = 8;
  // Reset vector address
  localparam logic [15:0] RST_VEC     = 16'h0000;
  // Upper byte fills
  localparam logic [7:0]  ABS8_HI     = 8'hFF;
  localparam logic [7:0]  MIND_HI     = 8'h00;
  // Flag register bit of the interrupt mask
  localparam int          MASK_BIT    = 7;
  // Stack pointer register index
  localparam logic [2:0]  SP_IDX      = 3'h7;
  // Step sizes
  localparam logic [15:0] STEP_BYTE   = 16'h0001;
  localparam logic [15:0] STEP_WORD   = 16'h0002;
  // Decimal adjust constants
  localparam logic [7:0]  BCD_LO_ADJ  = 8'h06;
  localparam logic [7:0]  BCD_HI_ADJ  = 8'h60;
  localparam logic [3:0]  BCD_MAX     = 4'h9;

  // Addressing modes
  typedef enum logic [3:0] {
    AM_REG, AM_IND, AM_DISP, AM_POSTINC, AM_PREDEC,
    AM_ABS8, AM_ABS16, AM_IMM8, AM_IMM16, AM_PCREL, AM_MEMIND
  } ceau_mode_t;

  // Instruction groups that matter for mode legality
  typedef enum logic [3:0] {
    OP_MOVE_BYTE, OP_MOVE_WORD, OP_ALU_B, OP_ALU_IMM_B, OP_ALU_W, OP_ADD_SMALL_CONST_SUBTRACT_SMALL_CONST,
    OP_MUL_DIV, OP_BIT, OP_BIT_REGNUM, OP_BRANCH, OP_JUMP, OP_DEC_ADJ,
    OP_FLAG_PUSH, OP_FLAG_POP
  } ceau_op_t;

  // Sequencer states
  typedef enum logic [1:0] {ST_RST_VEC, ST_IDLE, ST_IND_RD} ceau_state_t;
endpackage

// >>> src/ceau_bcd_adj.sv
// Packed decimal correction after add or subtract
`timescale 1ns/100ps
module ceau_bcd_adj (
  input  wire logic [7:0] val_in,     // Raw byte
  input  wire logic       sub_in,     // Subtract adjust
  input  wire logic       carry_in,   // Carry flag
  input  wire logic       half_in,    // Half carry flag
  output logic      [7:0] res_out,    // Adjusted byte
  output logic            carry_out   // Adjusted carry
);
  logic lo_fix;  // Low nibble correction
  logic hi_fix;  // High nibble correction
  // Pick nibble corrections, RL6
  always_comb begin
    if (sub_in) begin
      lo_fix = half_in;
      hi_fix = carry_in;
    end else begin
      lo_fix = half_in || (val_in[3:0] > ceau_pkg::BCD_MAX);
      hi_fix = carry_in || (val_in > {ceau_pkg::BCD_MAX, ceau_pkg::BCD_MAX});
    end
    if (sub_in) begin
      res_out = val_in - (lo_fix ? ceau_pkg::BCD_LO_ADJ : 8'h00)
                       - (hi_fix ? ceau_pkg::BCD_HI_ADJ : 8'h00); // RL6
    end else begin
      res_out = val_in + (lo_fix ? ceau_pkg::BCD_LO_ADJ : 8'h00)
                       + (hi_fix ? ceau_pkg::BCD_HI_ADJ : 8'h00); // RL6
    end
    carry_out = hi_fix;
  end
endmodule

// >>> src/ceau_core.sv
// Effective address unit with register file and reset vector load
`timescale 1ns/100ps
module ceau_core #(
  parameter int NREG = ceau_pkg::NREG   // General register count
) (
  input  wire logic        ref_clk_in,     // Clock
  input  wire logic        sys_rst_in,     // Synchronous reset
  // Request side
  input  wire logic        req_in,         // Operand request pulse
  input  wire logic [3:0]  mode_in,        // Addressing mode
  input  wire logic [3:0]  op_in,          // Instruction group
  input  wire logic        word_in,        // Word size
  input  wire logic [2:0]  reg_in,         // Register field
  input  wire logic [15:0] ext_in,         // Second instruction word
  input  wire logic [7:0]  byte2_in,       // Instruction byte 2
  input  wire logic [2:0]  bitnum_in,      // Immediate bit number
  input  wire logic        bitreg_in,      // Bit number from register
  input  wire logic [2:0]  bitsrc_in,      // Register holding bit number
  input  wire logic [15:0] pc_in,          // Current program counter
  // Register writes
  input  wire logic        wr_en_in,       // Register write
  input  wire logic [3:0]  wr_sel_in,      // Byte register select
  input  wire logic        wr_word_in,     // Whole word write
  input  wire logic [15:0] wr_data_in,     // Write data
  // Flag register access
  input  wire logic        flg_wr_in,      // Flag write
  input  wire logic [7:0]  flg_data_in,    // Flag data
  input  wire logic        flg_pop_in,     // Restore flags from stack word
  input  wire logic [15:0] pop_word_in,    // Stack word
  // Decimal adjust
  input  wire logic        bcd_req_in,     // Adjust request
  input  wire logic        bcd_sub_in,     // Subtract adjust
  input  wire logic [7:0]  bcd_val_in,     // Byte to adjust
  // Memory read data
  input  wire logic        mem_ack_in,     // Read data valid
  input  wire logic [15:0] mem_rdata_in,   // Read data
  // Outputs
  output logic             mem_rd_out,     // Memory word read strobe
  output logic [15:0]      mem_addr_out,   // Memory address
  output logic             ea_vld_out,     // Address result valid
  output logic [15:0]      ea_out,         // Effective address
  output logic [15:0]      imm_out,        // Immediate operand
  output logic [7:0]       bitmask_out,    // Selected bit mask
  output logic             bad_mode_out,   // Illegal mode for group
  output logic             pc_load_out,    // Load program counter
  output logic [15:0]      pc_out,         // Program counter value
  output logic [7:0]       flags_out,      // Flag register
  output logic [15:0]      push_word_out,  // Flag stack word
  output logic [15:0]      sp_out,         // Stack pointer
  output logic [7:0]       bcd_out         // Adjusted byte
);
  ceau_pkg::ceau_state_t state_ff;          // Sequencer state
  logic [15:0]   gpr_ff [NREG];             // General registers, not reset
  logic [7:0]    flags_ff;                  // Flag register
  logic          mem_rd_ff;                 // Read strobe
  logic [15:0]   mem_addr_ff;               // Read address
  logic          ea_vld_ff;                 // Result valid
  logic [15:0]   ea_ff;                     // Result address
  logic [15:0]   imm_ff;                    // Immediate
  logic [7:0]    bitmask_ff;                // Bit mask
  logic          bad_ff;                    // Mode error
  logic          pc_load_ff;                // PC load strobe
  logic [15:0]   pc_ff;                     // PC value
  logic [7:0]    bcd_ff;                    // Adjust result
  logic [15:0]   nxt_ea;                    // Computed address
  logic [15:0]   nxt_reg;                   // Updated base register
  logic          upd_reg;                   // Base register update
  logic          legal;                     // Mode legal for group
  logic [15:0]   step;                      // Byte or word step
  logic [15:0]   base;                      // Base register value
  logic [7:0]    bcd_res;                   // Adjuster result
  ceau_pkg::ceau_mode_t mode;               // Decoded mode
  ceau_pkg::ceau_op_t   op;                 // Decoded group

  assign mode = ceau_pkg::ceau_mode_t'(mode_in);
  assign op   = ceau_pkg::ceau_op_t'(op_in);
  assign base = gpr_ff[reg_in];
  assign step = word_in ? ceau_pkg::STEP_WORD : ceau_pkg::STEP_BYTE;

  // Mode legality per instruction group
  always_comb begin
    legal = 1'b0;
    case (op)
      ceau_pkg::OP_MOVE_BYTE:     legal = (mode != ceau_pkg::AM_PCREL) // RL21
                                   && (mode != ceau_pkg::AM_MEMIND)
                                   && (mode != ceau_pkg::AM_IMM16) && !word_in;
      ceau_pkg::OP_MOVE_WORD:     legal = (mode != ceau_pkg::AM_PCREL) // RL21
                                   && (mode != ceau_pkg::AM_MEMIND)
                                   && (mode != ceau_pkg::AM_ABS8)   // RL14
                                   && (mode != ceau_pkg::AM_IMM8) && word_in; // RL16
      ceau_pkg::OP_ALU_B:     legal = (mode == ceau_pkg::AM_REG) && !word_in; // RL20
      ceau_pkg::OP_ALU_IMM_B: legal = ((mode == ceau_pkg::AM_REG)
                                    || (mode == ceau_pkg::AM_IMM8)) && !word_in; // RL20
      ceau_pkg::OP_ALU_W,
      ceau_pkg::OP_MUL_DIV:   legal = (mode == ceau_pkg::AM_REG); // RL5
      ceau_pkg::OP_ADD_SMALL_CONST_SUBTRACT_SMALL_CONST: legal = (mode == ceau_pkg::AM_REG) && word_in; // RL5
      ceau_pkg::OP_DEC_ADJ:   legal = (mode == ceau_pkg::AM_REG) && !word_in; // RL6
      ceau_pkg::OP_BIT,
      ceau_pkg::OP_BIT_REGNUM: legal = ((mode == ceau_pkg::AM_REG)
                                     || (mode == ceau_pkg::AM_IND)
                                     || (mode == ceau_pkg::AM_ABS8)) && !word_in; // RL22
      ceau_pkg::OP_BRANCH:    legal = (mode == ceau_pkg::AM_PCREL); // RL18
      ceau_pkg::OP_JUMP:      legal = (mode == ceau_pkg::AM_IND)
                                   || (mode == ceau_pkg::AM_ABS16)  // RL15
                                   || (mode == ceau_pkg::AM_MEMIND); // RL19
      default:                legal = 1'b0;
    endcase
  end

  // Effective address and register side effects
  always_comb begin
    nxt_ea  = base;
    nxt_reg = base;
    upd_reg = 1'b0;
    case (mode)
      ceau_pkg::AM_DISP:    nxt_ea = base + ext_in;                 // RL10 RL24
      ceau_pkg::AM_POSTINC: begin
        nxt_reg = base + step;                                     // RL11 RL24
        upd_reg = 1'b1;
      end
      ceau_pkg::AM_PREDEC:  begin
        nxt_ea  = base - step;                                     // RL12 RL24
        nxt_reg = base - step;                                     // RL12
        upd_reg = 1'b1;
      end
      ceau_pkg::AM_ABS8:    nxt_ea = {ceau_pkg::ABS8_HI, byte2_in}; // RL14
      ceau_pkg::AM_ABS16:   nxt_ea = ext_in;                        // RL15
      ceau_pkg::AM_PCREL:   nxt_ea = pc_in + {{8{byte2_in[7]}}, byte2_in}; // RL18 RL24
      ceau_pkg::AM_MEMIND:  nxt_ea = {ceau_pkg::MIND_HI, byte2_in}; // RL19
      default:              nxt_ea = base;
    endcase
    // Word accesses and branch targets are even, RL7
    if (word_in || (mode == ceau_pkg::AM_PCREL) || (mode == ceau_pkg::AM_MEMIND)) begin
      nxt_ea[0] = 1'b0;                                            // RL7
    end
  end

  // Sequencer: reset vector fetch and memory indirect read
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_ff <= ceau_pkg::ST_RST_VEC;
    end else begin
      case (state_ff)
        ceau_pkg::ST_RST_VEC: if (mem_ack_in) state_ff <= ceau_pkg::ST_IDLE;
        ceau_pkg::ST_IDLE: begin
          if (req_in && legal && mode == ceau_pkg::AM_MEMIND) begin
            state_ff <= ceau_pkg::ST_IND_RD;
          end
        end
        ceau_pkg::ST_IND_RD:  if (mem_ack_in) state_ff <= ceau_pkg::ST_IDLE;
        default:              state_ff <= ceau_pkg::ST_IDLE;
      endcase
    end
  end

  // Memory read strobe and address
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      mem_rd_ff   <= 1'b1;
      mem_addr_ff <= ceau_pkg::RST_VEC;                            // RL1
    end else if (state_ff == ceau_pkg::ST_IDLE && req_in && legal
                 && mode == ceau_pkg::AM_MEMIND) begin
      mem_rd_ff   <= 1'b1;
      mem_addr_ff <= nxt_ea;                                       // RL19
    end else if (mem_ack_in) begin
      mem_rd_ff   <= 1'b0;
    end
  end

  // Program counter load from vector, indirect word or branch and jump target
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pc_load_ff <= 1'b0;
      pc_ff      <= 16'h0000;
    end else if (state_ff != ceau_pkg::ST_IDLE && mem_ack_in) begin
      pc_load_ff <= 1'b1;
      pc_ff      <= {mem_rdata_in[15:1], 1'b0};                    // RL1 RL19 RL7
    end else if (state_ff == ceau_pkg::ST_IDLE && req_in && legal
                 && (op == ceau_pkg::OP_BRANCH || (op == ceau_pkg::OP_JUMP
                 && mode != ceau_pkg::AM_MEMIND))) begin
      pc_load_ff <= 1'b1;
      pc_ff      <= nxt_ea;                                        // RL18 RL15
    end else begin
      pc_load_ff <= 1'b0;
    end
  end

  // Operand address result, immediate and bit mask
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ea_vld_ff  <= 1'b0;
      ea_ff      <= 16'h0000;
      imm_ff     <= 16'h0000;
      bitmask_ff <= 8'h00;
      bad_ff     <= 1'b0;
    end else begin
      ea_vld_ff <= req_in && legal && state_ff == ceau_pkg::ST_IDLE;
      bad_ff    <= req_in && !legal;
      if (req_in && legal && state_ff == ceau_pkg::ST_IDLE) begin
        ea_ff <= nxt_ea;
        if (mode == ceau_pkg::AM_IMM16) begin
          imm_ff <= ext_in;                                        // RL16
        end else if (mode == ceau_pkg::AM_IMM8) begin
          imm_ff <= {8'h00, byte2_in};                             // RL16
        end else if (op == ceau_pkg::OP_ADD_SMALL_CONST_SUBTRACT_SMALL_CONST) begin
          imm_ff <= step;                                          // RL17
        end
        if (bitreg_in) begin
          bitmask_ff <= 8'h01 << gpr_ff[bitsrc_in][2:0];           // RL22 RL4
        end else begin
          bitmask_ff <= 8'h01 << bitnum_in;                        // RL17 RL4
        end
      end
    end
  end

  // General registers: never reset, byte or word writes, RL2 RL23
  for (genvar g = 0; g < NREG; g++) begin : g_reg
    always_ff @(posedge ref_clk_in) begin
      if (wr_en_in && wr_sel_in[2:0] == 3'(g)) begin
        if (wr_word_in) begin
          gpr_ff[g] <= wr_data_in;                                 // RL23
        end else if (wr_sel_in[3]) begin
          gpr_ff[g][7:0] <= wr_data_in[7:0];                       // RL23
        end else begin
          gpr_ff[g][15:8] <= wr_data_in[7:0];                      // RL23
        end
      end else if (!sys_rst_in && req_in && legal && upd_reg
                   && state_ff == ceau_pkg::ST_IDLE && reg_in == 3'(g)) begin
        gpr_ff[g] <= nxt_reg;                                      // RL11 RL12
      end
    end
  end

  // Flag register: only mask bit set on reset, RL1 RL2
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      flags_ff[ceau_pkg::MASK_BIT] <= 1'b1;                        // RL1
    end else if (flg_pop_in) begin
      flags_ff <= pop_word_in[15:8];                               // RL8
    end else if (flg_wr_in) begin
      flags_ff <= flg_data_in;
    end
  end

  // Decimal adjust result
  ceau_bcd_adj u_bcd (
    .val_in    (bcd_val_in),
    .sub_in    (bcd_sub_in),
    .carry_in  (flags_ff[0]),
    .half_in   (flags_ff[5]),
    .res_out   (bcd_res),
    .carry_out ()
  );

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      bcd_ff <= 8'h00;
    end else if (bcd_req_in) begin
      bcd_ff <= bcd_res;                                           // RL6
    end
  end

  assign mem_rd_out    = mem_rd_ff;
  assign mem_addr_out  = mem_addr_ff;
  assign ea_vld_out    = ea_vld_ff;
  assign ea_out        = ea_ff;
  assign imm_out       = imm_ff;
  assign bitmask_out   = bitmask_ff;
  assign bad_mode_out  = bad_ff;
  assign pc_load_out   = pc_load_ff;
  assign pc_out        = pc_ff;
  assign flags_out     = flags_ff;
  assign push_word_out = {flags_ff, flags_ff};                     // RL8
  assign sp_out        = gpr_ff[ceau_pkg::SP_IDX];                 // RL23
  assign bcd_out       = bcd_ff;

  // Checks
  property p_rst_vec;
    @(posedge ref_clk_in) sys_rst_in |=> mem_rd_out && mem_addr_out == ceau_pkg::RST_VEC;
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("reset vector read missing"); // RL1

  property p_mask;
    @(posedge ref_clk_in) sys_rst_in |=> flags_out[ceau_pkg::MASK_BIT];
  endproperty
  a_mask: assert property (p_mask) else $error("mask not set on reset"); // RL1

  property p_even_pc;
    @(posedge ref_clk_in) disable iff (sys_rst_in) pc_load_out |-> !pc_out[0];
  endproperty
  a_even_pc: assert property (p_even_pc) else $error("odd pc"); // RL7

  property p_push;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      flg_wr_in && !flg_pop_in |=> push_word_out == {2{$past(flg_data_in)}};
  endproperty
  a_push: assert property (p_push) else $error("push halves differ"); // RL8

  property p_abs8;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (req_in && legal && mode == ceau_pkg::AM_ABS8 && state_ff == ceau_pkg::ST_IDLE)
      |=> ea_out[15:8] == ceau_pkg::ABS8_HI;
  endproperty
  a_abs8: assert property (p_abs8) else $error("short absolute high byte"); // RL14

  property p_postinc;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (req_in && legal && mode == ceau_pkg::AM_POSTINC && !wr_en_in
       && state_ff == ceau_pkg::ST_IDLE)
      |=> gpr_ff[$past(reg_in)] == $past(base) + $past(step);
  endproperty
  a_postinc: assert property (p_postinc) else $error("post increment"); // RL11

  property p_predec;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (req_in && legal && mode == ceau_pkg::AM_PREDEC && !wr_en_in
       && state_ff == ceau_pkg::ST_IDLE)
      |=> ea_out == $past(base) - $past(step) && ea_out == gpr_ff[$past(reg_in)];
  endproperty
  a_predec: assert property (p_predec) else $error("pre decrement"); // RL12

  // Indirect jump: pointer word answer, then even target
  sequence s_ind_ack;
    state_ff == ceau_pkg::ST_IND_RD && mem_ack_in;
  endsequence
  sequence s_pc_even;
    pc_load_out && !pc_out[0];
  endsequence
  property p_ind_pc;
    @(posedge ref_clk_in) disable iff (sys_rst_in) s_ind_ack |=> s_pc_even;
  endproperty
  a_ind_pc: assert property (p_ind_pc) else $error("indirect jump lost"); // RL19

  // Refused group and mode pairs
  property p_bad;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      req_in && !legal |=> bad_mode_out && !ea_vld_out;
  endproperty
  a_bad: assert property (p_bad) else $error("illegal mode accepted"); // RL21

  property p_bit;
    @(posedge ref_clk_in) disable iff (sys_rst_in) ea_vld_out |-> $onehot(bitmask_out);
  endproperty
  a_bit: assert property (p_bit) else $error("bit mask"); // RL4
endmodule

// >>> sim/ceau_mem_model.sv
// Program and data memory answering word reads of the core
`timescale 1ns/100ps
module ceau_mem_model #(
  parameter logic [15:0] VEC_WORD = 16'h1235  // Reset vector contents
) (
  input  wire logic        ref_clk_in,    // Clock
  input  wire logic        sys_rst_in,    // Synchronous reset
  input  wire logic [1:0]  lat_in,        // Answer delay in cycles
  input  wire logic        mem_rd_in,     // Read strobe from core
  input  wire logic [15:0] mem_addr_in,   // Read address
  output logic             mem_ack_out,   // Read data valid
  output logic [15:0]      mem_rdata_out  // Read data
);
  logic [1:0] wait_ff;  // Cycles waited so far
  logic       done_ff;  // Answered, strobe not yet dropped
  // One word per strobe; data toggles outside the ack so stale values never match
  always_ff @(posedge ref_clk_in) begin
    mem_ack_out   <= 1'b0;
    mem_rdata_out <= ~mem_rdata_out;
    if (sys_rst_in || !mem_rd_in) begin
      wait_ff <= 2'h0;
      done_ff <= 1'b0;
      if (sys_rst_in) mem_rdata_out <= 16'h0F0F;
    end else if (!done_ff && wait_ff == lat_in) begin
      // Vector word at zero, a pattern of the address elsewhere
      mem_ack_out   <= 1'b1;
      done_ff       <= 1'b1;
      mem_rdata_out <= (mem_addr_in == 16'h0000) ? VEC_WORD :
                       {mem_addr_in[7:0] ^ 8'h5A, mem_addr_in[7:0]};
    end else if (!done_ff) begin
      wait_ff <= wait_ff + 2'h1;
    end
  end
endmodule

// >>> sim/cpu_effective_address_unit_bench.sv
// Self-checking bench of the effective address unit
`timescale 1ns/100ps
module cpu_effective_address_unit_bench;
  // One table row: request and its expected answer
  typedef struct {
    logic [3:0]  mode;
    logic [3:0]  op;
    logic        w;
    logic [15:0] rv;
    logic [15:0] ext;
    logic [7:0]  b2;
    logic        bad;
    logic [15:0] ea;
    logic [15:0] sp;
  } ceau_row_t;
  ceau_row_t   rows [12];  // Ordinary cases
  logic        clk, rst, req, word, bitreg, wr_en, wr_word, flg_wr, flg_pop, bcd_req, bcd_sub;
  logic [3:0]  mode, op, wr_sel;
  logic [2:0]  reg_sel, bitnum, bitsrc;
  logic [7:0]  byte2, flg_data, bcd_val, bitmask, flags, bcd;
  logic [15:0] ext, pc_val, wr_data, pop_word, rdata, mem_addr, ea, imm, pc, push_word, sp;
  logic        ack, mem_rd, ea_vld, bad, pc_load;
  logic [1:0]  lat;        // Memory answer delay
  int          error_cnt;  // Mismatches
  int          tests_run;  // Comparisons
  int          cyc_cnt;    // Cycles for the hang guard

  ceau_core dut_u (
    .ref_clk_in(clk), .sys_rst_in(rst), .req_in(req), .mode_in(mode), .op_in(op),
    .word_in(word), .reg_in(reg_sel), .ext_in(ext), .byte2_in(byte2), .bitnum_in(bitnum),
    .bitreg_in(bitreg), .bitsrc_in(bitsrc), .pc_in(pc_val), .wr_en_in(wr_en),
    .wr_sel_in(wr_sel), .wr_word_in(wr_word), .wr_data_in(wr_data), .flg_wr_in(flg_wr),
    .flg_data_in(flg_data), .flg_pop_in(flg_pop), .pop_word_in(pop_word),
    .bcd_req_in(bcd_req), .bcd_sub_in(bcd_sub), .bcd_val_in(bcd_val), .mem_ack_in(ack),
    .mem_rdata_in(rdata), .mem_rd_out(mem_rd), .mem_addr_out(mem_addr), .ea_vld_out(ea_vld),
    .ea_out(ea), .imm_out(imm), .bitmask_out(bitmask), .bad_mode_out(bad),
    .pc_load_out(pc_load), .pc_out(pc), .flags_out(flags), .push_word_out(push_word),
    .sp_out(sp), .bcd_out(bcd));
  ceau_mem_model mem_u (
    .ref_clk_in(clk), .sys_rst_in(rst), .lat_in(lat), .mem_rd_in(mem_rd),
    .mem_addr_in(mem_addr), .mem_ack_out(ack), .mem_rdata_out(rdata));

  // Clock of 50 ns period
  always #25 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 4000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // Counts and verdict
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Wait n rising edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Word or byte register write
  task automatic wr_reg(input logic [3:0] s, input logic wd, input logic [15:0] d);
    wr_en = 1'b1;
    wr_sel = s;
    wr_word = wd;
    wr_data = d;
    cyc(1);
    wr_en = 1'b0;
    cyc(1);
  endtask

  // Flag register write
  task automatic set_flags(input logic [7:0] d);
    flg_wr = 1'b1;
    flg_data = d;
    cyc(1);
    flg_wr = 1'b0;
    cyc(1);
  endtask

  // One request pulse, then a bounded wait for any answer
  task automatic do_req(input logic [3:0] md, input logic [3:0] o, input logic w,
                        input logic [15:0] e, input logic [7:0] b);
    int k;
    cyc(1);
    mode = md;
    op = o;
    word = w;
    ext = e;
    byte2 = b;
    req = 1'b1;
    cyc(1);
    req = 1'b0;
    k = 0;
    while (!(ea_vld === 1'b1 || bad === 1'b1 || mem_rd === 1'b1) && k < 20) begin
      cyc(1);
      k++;
    end
  endtask

  // Bounded wait for a program counter load
  task automatic wait_pc();
    int k;
    k = 0;
    while (pc_load !== 1'b1 && k < 40) begin
      cyc(1);
      k++;
    end
    check({15'h0000, pc_load}, 16'h0001);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {req, word, bitreg, wr_en, wr_word, flg_wr, flg_pop, bcd_req, bcd_sub} = '0;
    {mode, op, wr_sel, bitnum, bitsrc, flg_data, bcd_val, byte2, lat} = '0;
    {ext, pc_val, wr_data, pop_word} = '0;
    reg_sel = 3'h7;
    error_cnt = 0;
    tests_run = 0;
    cyc_cnt = 0;
    // Word rows keep even addresses on the stack register
    rows = '{
      '{ceau_pkg::AM_ABS8, ceau_pkg::OP_MOVE_BYTE, 1'b0, 16'h0100, 16'h0, 8'h3C, 1'b0, 16'hFF3C, 16'h0100},
      '{ceau_pkg::AM_IND, ceau_pkg::OP_MOVE_WORD, 1'b1, 16'h2468, 16'h0, 8'h0, 1'b0, 16'h2468, 16'h2468},
      '{ceau_pkg::AM_DISP, ceau_pkg::OP_MOVE_WORD, 1'b1, 16'hFFF0, 16'h0020, 8'h0, 1'b0, 16'h0010, 16'hFFF0},
      '{ceau_pkg::AM_POSTINC, ceau_pkg::OP_MOVE_WORD, 1'b1, 16'hFFFE, 16'h0, 8'h0, 1'b0, 16'hFFFE, 16'h0},
      '{ceau_pkg::AM_PREDEC, ceau_pkg::OP_MOVE_WORD, 1'b1, 16'h0, 16'h0, 8'h0, 1'b0, 16'hFFFE, 16'hFFFE},
      '{ceau_pkg::AM_ABS16, ceau_pkg::OP_JUMP, 1'b0, 16'h0200, 16'h4444, 8'h0, 1'b0, 16'h4444, 16'h0200},
      '{ceau_pkg::AM_ABS16, ceau_pkg::OP_ALU_B, 1'b0, 16'h0202, 16'h4444, 8'h0, 1'b1, 16'h0, 16'h0202},
      '{ceau_pkg::AM_ABS8, ceau_pkg::OP_MOVE_WORD, 1'b1, 16'h0204, 16'h0, 8'h10, 1'b1, 16'h0, 16'h0204},
      '{ceau_pkg::AM_PCREL, ceau_pkg::OP_MOVE_BYTE, 1'b0, 16'h0206, 16'h0, 8'h10, 1'b1, 16'h0, 16'h0206},
      '{ceau_pkg::AM_DISP, ceau_pkg::OP_BIT, 1'b0, 16'h0208, 16'h0010, 8'h0, 1'b1, 16'h0, 16'h0208},
      '{ceau_pkg::AM_IMM16, ceau_pkg::OP_ALU_IMM_B, 1'b0, 16'h020A, 16'h1, 8'h0, 1'b1, 16'h0, 16'h020A},
      '{ceau_pkg::AM_IMM8, ceau_pkg::OP_ALU_B, 1'b0, 16'h020C, 16'h0, 8'h01, 1'b1, 16'h0, 16'h020C}};
    cyc(20);
    rst = 1'b0;
    wait_pc();
    check(pc, 16'h1234);
    check({15'h0000, flags[7]}, 16'h0001);
    wr_reg(4'h7, 1'b1, 16'h0100);
    foreach (rows[i]) begin
      wr_reg(4'h7, 1'b1, rows[i].rv);
      do_req(rows[i].mode, rows[i].op, rows[i].w, rows[i].ext, rows[i].b2);
      check({15'h0000, bad}, {15'h0000, rows[i].bad});
      check({15'h0000, ea_vld}, {15'h0000, !rows[i].bad});
      if (!rows[i].bad) check(ea, rows[i].ea);
      cyc(1);
      check(sp, rows[i].sp);
    end
    // Byte halves of the stack register
    wr_reg(4'h7, 1'b0, 16'hABAB);
    wr_reg(4'hF, 1'b0, 16'h5656);
    check(sp, 16'hAB56);
    // Byte steps on a non-stack register
    reg_sel = 3'h2;
    wr_reg(4'hA, 1'b1, 16'h1000);
    do_req(ceau_pkg::AM_POSTINC, ceau_pkg::OP_MOVE_BYTE, 1'b0, 16'h0, 8'h0);
    check(ea, 16'h1000);
    do_req(ceau_pkg::AM_PREDEC, ceau_pkg::OP_MOVE_BYTE, 1'b0, 16'h0, 8'h0);
    check(ea, 16'h1000);
    for (int b = 0; b < 8; b++) begin
      bitnum = b[2:0];
      do_req(ceau_pkg::AM_REG, ceau_pkg::OP_BIT, 1'b0, 16'h0, 8'h0);
      check({8'h00, bitmask}, {8'h00, 8'h01 << b});
    end
    wr_reg(4'hA, 1'b1, 16'h000D);
    {bitreg, bitsrc} = {1'b1, 3'h2};
    do_req(ceau_pkg::AM_IND, ceau_pkg::OP_BIT_REGNUM, 1'b0, 16'h0, 8'h0);
    check({8'h00, bitmask}, 16'h0020);
    bitreg = 1'b0;
    do_req(ceau_pkg::AM_IMM8, ceau_pkg::OP_ALU_IMM_B, 1'b0, 16'h0, 8'hC3);
    check({8'h00, imm[7:0]}, 16'h00C3);
    do_req(ceau_pkg::AM_IMM16, ceau_pkg::OP_MOVE_WORD, 1'b1, 16'h5AA4, 8'h0);
    check(imm, 16'h5AA4);
    do_req(ceau_pkg::AM_REG, ceau_pkg::OP_ADD_SMALL_CONST_SUBTRACT_SMALL_CONST, 1'b1, 16'h0, 8'h0);
    check(imm, 16'h0002);
    pc_val = 16'h1000;
    do_req(ceau_pkg::AM_PCREL, ceau_pkg::OP_BRANCH, 1'b0, 16'h0, 8'h80);
    cyc(1);
    check(pc, 16'h0F80);
    pc_val = 16'hFFF0;
    do_req(ceau_pkg::AM_PCREL, ceau_pkg::OP_BRANCH, 1'b0, 16'h0, 8'h20);
    cyc(1);
    check(pc, 16'h0010);
    lat = 2'h3;
    do_req(ceau_pkg::AM_MEMIND, ceau_pkg::OP_JUMP, 1'b0, 16'h0, 8'h41);
    check(mem_addr, 16'h0040);
    check({15'h0000, mem_rd}, 16'h0001);
    wait_pc();
    check(pc, 16'h1A40);
    set_flags(8'h5A);
    check(push_word, 16'h5A5A);
    {flg_pop, pop_word} = {1'b1, 16'h3CC3};
    cyc(1);
    flg_pop = 1'b0;
    cyc(1);
    check({8'h00, flags}, 16'h003C);
    set_flags(8'h00);
    {bcd_req, bcd_val} = {1'b1, 8'h1A};
    cyc(1);
    bcd_req = 1'b0;
    cyc(1);
    check({8'h00, bcd}, 16'h0020);
    set_flags(8'h25);
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    wait_pc();
    check(pc, 16'h1234);
    check({8'h00, flags}, 16'h00A5);
    check(sp, 16'hAB56);
    report_and_stop();
  end
endmodule
